// File: design/rtcam_alarm_core.sv
module rtcam_alarm_core (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    // wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // current timekeeping values, bcd
    input  wire logic        time_update_tick,
    input  wire logic [6:0]  tk_seconds,
    input  wire logic [6:0]  tk_minutes,
    input  wire logic [6:0]  tk_hours,
    input  wire logic [2:0]  tk_weekday,
    input  wire logic [5:0]  tk_monthday,
    // square wave source and shared pin
    input  wire logic        sq_wave_in,
    output logic             irq_or_wave_out_n,
    output logic      [1:0]  wave_rate_sel
);

    rtcam_pkg::rtcam_state_t st_reg;
    rtcam_pkg::rtcam_state_t st_next;

    logic        req;
    logic        wr_en;
    logic [3:0]  idx;
    logic        a1_match;
    logic        a2_match;
    logic        a1_set;
    logic        a2_set;
    logic        irq_active;

    // masked field compare; raw byte compare keeps bcd and 12/24 bits
    function automatic logic field_hit(
        input logic [7:0] setting,
        input logic [6:0] current
    );
        field_hit = setting[rtcam_pkg::MASK_BIT]
                    | (setting[6:0] == current);
    endfunction : field_hit

    // day field: selector picks weekday or day of month
    function automatic logic day_hit(
        input logic [7:0] setting,
        input logic [2:0] weekday,
        input logic [5:0] monthday
    );
        logic [5:0] cur;
        cur = setting[rtcam_pkg::DAYSEL_BIT] ? {3'h0, weekday}
                                             : monthday;
        day_hit = setting[rtcam_pkg::MASK_BIT]
                  | (setting[rtcam_pkg::DAY_MSB:0] == cur);
    endfunction : day_hit

    assign req   = wb_cyc_i & wb_stb_i & ~st_reg.ack;
    assign wr_en = req & wb_we_i & wb_sel_i[0];
    assign idx   = wb_adr_i[5:2];

    // first alarm: seconds, minutes, hours, day/date
    assign a1_match =
        field_hit(st_reg.alarm[0], tk_seconds)
        & field_hit(st_reg.alarm[1], tk_minutes)
        & field_hit(st_reg.alarm[2], tk_hours)
        & day_hit(st_reg.alarm[3], tk_weekday,
                  tk_monthday);

    // second alarm has no seconds field, so it fires at seconds zero
    assign a2_match =
        (tk_seconds == rtcam_pkg::SECONDS_ZERO)
        & field_hit(st_reg.alarm[4], tk_minutes)
        & field_hit(st_reg.alarm[5], tk_hours)
        & day_hit(st_reg.alarm[6], tk_weekday,
                  tk_monthday);

    // only the update strobe may set a flag
    assign a1_set = time_update_tick & a1_match;
    assign a2_set = time_update_tick & a2_match;

    assign irq_active =
        st_reg.ctrl[rtcam_pkg::CTRL_IRQ_MODE]
        & ((st_reg.flag[rtcam_pkg::STAT_A1_FLAG]
            & st_reg.ctrl[rtcam_pkg::CTRL_A1_IE])
           | (st_reg.flag[rtcam_pkg::STAT_A2_FLAG]
              & st_reg.ctrl[rtcam_pkg::CTRL_A2_IE]));

    always_comb begin
        st_next     = st_reg;
        st_next.ack = req;
        if (req) begin
            st_next.rdata = rtcam_pkg::RDATA_ZERO;
            case (idx)
                rtcam_pkg::IDX_A1_SECONDS,
                rtcam_pkg::IDX_A1_MINUTES,
                rtcam_pkg::IDX_A1_HOURS,
                rtcam_pkg::IDX_A1_DAY,
                rtcam_pkg::IDX_A2_MINUTES,
                rtcam_pkg::IDX_A2_HOURS,
                rtcam_pkg::IDX_A2_DAY: begin
                    st_next.rdata[7:0] =
                        st_reg.alarm[3'(idx - rtcam_pkg::IDX_A1_SECONDS)];
                    if (wr_en) begin
                        st_next.alarm[3'(idx - rtcam_pkg::IDX_A1_SECONDS)] =
                            wb_dat_i[7:0];
                    end
                end
                rtcam_pkg::IDX_CONTROL: begin
                    st_next.rdata[7:0] = st_reg.ctrl;
                    if (wr_en) begin
                        st_next.ctrl = wb_dat_i[7:0];
                    end
                end
                rtcam_pkg::IDX_STATUS: begin
                    st_next.rdata[1:0] = st_reg.flag;
                    if (wr_en) begin
                        // ones leave a flag alone, zeros clear it
                        st_next.flag = st_reg.flag & wb_dat_i[1:0];
                    end
                end
                default: begin
                    // unmapped: acknowledged, reads zero, writes dropped
                    st_next.rdata = rtcam_pkg::RDATA_ZERO;
                end
            endcase
        end
        // set applied last so it wins over a same-cycle clear
        if (a1_set) begin
            st_next.flag[rtcam_pkg::STAT_A1_FLAG] = 1'h1;
        end
        if (a2_set) begin
            st_next.flag[rtcam_pkg::STAT_A2_FLAG] = 1'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg.alarm <= {rtcam_pkg::ALARM_REGS{rtcam_pkg::ALARM_RESET}};
            st_reg.ctrl  <= rtcam_pkg::CTRL_RESET;
            st_reg.flag  <= 2'h0;
            st_reg.ack   <= 1'b0;
            st_reg.rdata <= rtcam_pkg::RDATA_ZERO;
        end else begin
            st_reg <= st_next;
        end
    end

    assign wb_ack_o = st_reg.ack;
    assign wb_dat_o = st_reg.rdata;
    assign wave_rate_sel = st_reg.ctrl[rtcam_pkg::CTRL_RATE_HI:
                                       rtcam_pkg::CTRL_RATE_LO];
    // pin mux; square wave generation itself lives elsewhere
    assign irq_or_wave_out_n = st_reg.ctrl[rtcam_pkg::CTRL_IRQ_MODE]
                               ? ~irq_active
                               : sq_wave_in;

    // checks, all on the one clock
    logic status_wr;
    assign status_wr = wr_en & (idx == rtcam_pkg::IDX_STATUS);

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    property p_a1_every_second;
        time_update_tick && (st_reg.alarm[0][7] && st_reg.alarm[1][7]
            && st_reg.alarm[2][7] && st_reg.alarm[3][7])
        |=> st_reg.flag[0];
    endproperty
    a_a1_every_second: assert property (p_a1_every_second)
        else $error("alarm1 all masked did not set flag");

    property p_flag_only_on_tick;
        $rose(st_reg.flag[0]) || $rose(st_reg.flag[1])
        |-> $past(time_update_tick);
    endproperty
    a_flag_only_on_tick: assert property (p_flag_only_on_tick)
        else $error("alarm flag set without update tick");

    property p_a1_seconds;
        time_update_tick && st_reg.alarm[1][7] && st_reg.alarm[2][7]
            && st_reg.alarm[3][7] && !st_reg.alarm[0][7]
            && st_reg.alarm[0][6:0] != tk_seconds && !st_reg.flag[0]
        |=> !st_reg.flag[0];
    endproperty
    a_a1_seconds: assert property (p_a1_seconds)
        else $error("alarm1 set on seconds mismatch");

    property p_a2_sec_zero;
        time_update_tick && tk_seconds != 7'h00 && !st_reg.flag[1]
        |=> !st_reg.flag[1];
    endproperty
    a_a2_sec_zero: assert property (p_a2_sec_zero)
        else $error("alarm2 set away from seconds zero");

    property p_flag_clear;
        status_wr && !wb_dat_i[0] && !time_update_tick
        |=> !st_reg.flag[0] ##1 wb_ack_o == 1'b0;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("zero write did not clear flag");

    property p_write_one_keeps;
        status_wr && wb_dat_i[1] && !time_update_tick
        |=> st_reg.flag[1] == $past(st_reg.flag[1]);
    endproperty
    a_write_one_keeps: assert property (p_write_one_keeps)
        else $error("one write changed flag");

    property p_irq_pin;
        st_reg.ctrl[2] && st_reg.flag[0] && st_reg.ctrl[0]
        |-> !irq_or_wave_out_n;
    endproperty
    a_irq_pin: assert property (p_irq_pin)
        else $error("enabled flag did not pull pin low");

    property p_pin_released;
        st_reg.ctrl[2] && !(st_reg.flag[0] && st_reg.ctrl[0])
            && !(st_reg.flag[1] && st_reg.ctrl[1])
        |-> irq_or_wave_out_n;
    endproperty
    a_pin_released: assert property (p_pin_released)
        else $error("pin low with no enabled flag");

    property p_wave_mode;
        !st_reg.ctrl[2] |-> irq_or_wave_out_n == sq_wave_in;
    endproperty
    a_wave_mode: assert property (p_wave_mode)
        else $error("pin not carrying square wave");

    property p_day_select;
        time_update_tick && !st_reg.alarm[3][7] && st_reg.alarm[3][6]
            && st_reg.alarm[3][5:0] != {3'b000, tk_weekday}
            && !st_reg.flag[0] && !status_wr
        |=> !st_reg.flag[0];
    endproperty
    a_day_select: assert property (p_day_select)
        else $error("weekday mismatch set alarm1");

    property p_set_wins;
        time_update_tick && st_reg.alarm[0][7] && st_reg.alarm[1][7]
            && st_reg.alarm[2][7] && st_reg.alarm[3][7]
            && status_wr && !wb_dat_i[0]
        |=> st_reg.flag[0];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("same cycle clear beat alarm1 set");

    property p_a1_write;
        wr_en && idx == rtcam_pkg::IDX_A1_SECONDS
        |=> st_reg.alarm[0] == $past(wb_dat_i[7:0]);
    endproperty
    a_a1_write: assert property (p_a1_write)
        else $error("alarm1 seconds write lost");

    property p_a1_full_date;
        time_update_tick && !st_reg.alarm[0][7] && !st_reg.alarm[1][7]
            && !st_reg.alarm[2][7] && !st_reg.alarm[3][7]
            && !st_reg.alarm[3][6] && st_reg.alarm[3][5:0] == tk_monthday
            && st_reg.alarm[0][6:0] == tk_seconds
            && st_reg.alarm[1][6:0] == tk_minutes
            && st_reg.alarm[2][6:0] == tk_hours
        |=> st_reg.flag[0];
    endproperty
    a_a1_full_date: assert property (p_a1_full_date)
        else $error("alarm1 full date match missed");

    property p_a1_minutes;
        time_update_tick && !st_reg.alarm[1][7]
            && st_reg.alarm[1][6:0] != tk_minutes && !st_reg.flag[0]
        |=> !st_reg.flag[0];
    endproperty
    a_a1_minutes: assert property (p_a1_minutes)
        else $error("alarm1 set on minutes mismatch");

    property p_a1_hours;
        time_update_tick && !st_reg.alarm[2][7]
            && st_reg.alarm[2][6:0] != tk_hours && !st_reg.flag[0]
        |=> !st_reg.flag[0];
    endproperty
    a_a1_hours: assert property (p_a1_hours)
        else $error("alarm1 set on hours mismatch");

    property p_a2_on_minute;
        time_update_tick && tk_seconds == 7'h00 && st_reg.alarm[4][7]
            && st_reg.alarm[5][7] && st_reg.alarm[6][7]
        |=> st_reg.flag[1];
    endproperty
    a_a2_on_minute: assert property (p_a2_on_minute)
        else $error("alarm2 all masked missed seconds zero");

    property p_a2_minutes;
        time_update_tick && !st_reg.alarm[4][7]
            && st_reg.alarm[4][6:0] != tk_minutes && !st_reg.flag[1]
        |=> !st_reg.flag[1];
    endproperty
    a_a2_minutes: assert property (p_a2_minutes)
        else $error("alarm2 set on minutes mismatch");

    property p_a2_hours;
        time_update_tick && !st_reg.alarm[5][7]
            && st_reg.alarm[5][6:0] != tk_hours && !st_reg.flag[1]
        |=> !st_reg.flag[1];
    endproperty
    a_a2_hours: assert property (p_a2_hours)
        else $error("alarm2 set on hours mismatch");

    property p_a2_date;
        time_update_tick && !st_reg.alarm[6][7] && !st_reg.alarm[6][6]
            && st_reg.alarm[6][5:0] != tk_monthday && !st_reg.flag[1]
        |=> !st_reg.flag[1];
    endproperty
    a_a2_date: assert property (p_a2_date)
        else $error("alarm2 set on date mismatch");

    property p_a2_weekday;
        time_update_tick && !st_reg.alarm[6][7] && st_reg.alarm[6][6]
            && st_reg.alarm[6][5:0] != {3'h0, tk_weekday}
            && !st_reg.flag[1]
        |=> !st_reg.flag[1];
    endproperty
    a_a2_weekday: assert property (p_a2_weekday)
        else $error("alarm2 set on weekday mismatch");

    property p_keep_a1;
        status_wr && wb_dat_i[0] && !time_update_tick
        |=> st_reg.flag[0] == $past(st_reg.flag[0]);
    endproperty
    a_keep_a1: assert property (p_keep_a1)
        else $error("one write changed alarm1 flag");

endmodule : rtcam_alarm_core

// File: design/rtcam_pkg.sv
package rtcam_pkg;

    // register indices; byte address is four times the index
    localparam logic [3:0] IDX_A1_SECONDS = 4'h7;
    localparam logic [3:0] IDX_A1_MINUTES = 4'h8;
    localparam logic [3:0] IDX_A1_HOURS   = 4'h9;
    localparam logic [3:0] IDX_A1_DAY     = 4'hA;
    localparam logic [3:0] IDX_A2_MINUTES = 4'hB;
    localparam logic [3:0] IDX_A2_HOURS   = 4'hC;
    localparam logic [3:0] IDX_A2_DAY     = 4'hD;
    localparam logic [3:0] IDX_CONTROL    = 4'hE;
    localparam logic [3:0] IDX_STATUS     = 4'hF;
    localparam int         ALARM_REGS     = 7;

    // field positions in alarm registers
    localparam int MASK_BIT  = 7;
    localparam int DAYSEL_BIT = 6;
    localparam int DAY_MSB   = 5;

    // control register fields
    localparam int CTRL_A1_IE   = 0;
    localparam int CTRL_A2_IE   = 1;
    localparam int CTRL_IRQ_MODE = 2;
    localparam int CTRL_RATE_LO = 3;
    localparam int CTRL_RATE_HI = 4;
    localparam logic [7:0] CTRL_RESET = 8'h1C;

    // status register fields
    localparam int STAT_A1_FLAG = 0;
    localparam int STAT_A2_FLAG = 1;

    localparam logic [7:0]  ALARM_RESET = 8'h00;
    localparam logic [6:0]  SECONDS_ZERO = 7'h00;
    localparam logic [31:0] RDATA_ZERO  = 32'h0000_0000;

    typedef struct packed {
        logic [ALARM_REGS-1:0][7:0] alarm;
        logic [7:0]                 ctrl;
        logic [1:0]                 flag;
        logic                       ack;
        logic [31:0]                rdata;
    } rtcam_state_t;

endpackage : rtcam_pkg

// File: tb/rtcam_host_model.sv
module rtcam_host_model (
    // clock
    input  wire logic        ref_clk,
    // wishbone classic master
    output logic             wb_cyc,
    output logic             wb_stb,
    output logic             wb_we,
    output logic      [5:0]  wb_adr,
    output logic      [3:0]  wb_sel,
    output logic      [31:0] wb_dat,
    input  wire logic [31:0] wb_dat_in,
    input  wire logic        wb_ack
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        wb_cyc <= 1'h0;
        wb_stb <= 1'h0;
        wb_we  <= 1'h0;
        wb_adr <= 6'h00;
        wb_sel <= 4'h0;
        wb_dat <= 32'h0000_0000;
    end

    // holds the request until ack; a dead slave is cut by the bench timeout
    task automatic xfer(input logic w, input logic [3:0] idx,
                        input logic [7:0] d, output logic [7:0] q);
        @(posedge ref_clk);
        wb_cyc <= 1'h1;
        wb_stb <= 1'h1;
        wb_we  <= w;
        wb_sel <= 4'hF;
        wb_adr <= {idx, 2'h0};
        wb_dat <= {24'h00_0000, d};
        do @(posedge ref_clk); while (wb_ack !== 1'h1);
        q = wb_dat_in[7:0];
        wb_cyc <= 1'h0;
        wb_stb <= 1'h0;
        wb_we  <= 1'h0;
    endtask : xfer
endmodule : rtcam_host_model

// File: tb/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [55:0] al;
        logic [7:0]  s;
        logic [1:0]  fl;
    } rtcam_row_t;

    logic        ref_clk = 1'h0;
    logic        arst_n  = 1'h0;
    logic        tick    = 1'h0;
    logic        sq      = 1'h0;
    logic [6:0]  sec     = 7'h00;
    logic [7:0]  q;
    logic        cyc, stb, we, ack, pin;
    logic [5:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat;
    logic [1:0]  rate;
    int          n_fail = 0;
    int          tests_run = 0;
    int          cyc_cnt = 0;

    // only listed mask patterns are used
    rtcam_row_t rows [13] = '{
        '{56'h80_8080_8080_8080, 8'h30, 2'h1},
        '{56'h30_8080_8045_8080, 8'h30, 2'h1},
        '{56'h31_8080_8045_8080, 8'h00, 2'h2},
        '{56'h30_4580_8044_8080, 8'h30, 2'h1},
        '{56'h00_4680_8045_1280, 8'h00, 2'h2},
        '{56'h30_4512_8045_1380, 8'h30, 2'h1},
        '{56'h30_4512_2145_1221, 8'h30, 2'h1},
        '{56'h00_4512_4345_1221, 8'h00, 2'h3},
        '{56'h00_4512_0345_1243, 8'h00, 2'h2},
        '{56'h00_4511_8045_1222, 8'h00, 2'h0},
        '{56'h00_4512_6145_1243, 8'h00, 2'h2},
        '{56'h00_4512_2145_1261, 8'h00, 2'h1},
        '{56'h80_8080_8080_8080, 8'h00, 2'h3}
    };

    always #20 ref_clk = ~ref_clk;

    rtcam_host_model host (.ref_clk(ref_clk), .wb_cyc(cyc), .wb_stb(stb),
        .wb_we(we), .wb_adr(adr), .wb_sel(sel), .wb_dat(wdat),
        .wb_dat_in(rdat), .wb_ack(ack));

    rtcam_alarm_core uut (.ref_clk(ref_clk), .arst_n(arst_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .time_update_tick(tick), .tk_seconds(sec), .tk_minutes(7'h45),
        .tk_hours(7'h12), .tk_weekday(3'h3), .tk_monthday(6'h21),
        .sq_wave_in(sq), .irq_or_wave_out_n(pin), .wave_rate_sel(rate));

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [3:0] i, input logic [7:0] d);
        host.xfer(1'h1, i, d, q);
    endtask : wr

    task automatic rd(input logic [3:0] i);
        host.xfer(1'h0, i, 8'h00, q);
    endtask : rd

    // the one-second update, looked at once its edge has landed
    task automatic tk(input logic [6:0] s);
        @(posedge ref_clk);
        sec  <= s;
        tick <= 1'h1;
        @(posedge ref_clk);
        tick <= 1'h0;
        @(negedge ref_clk);
    endtask : tk

    task automatic rst();
        arst_n <= 1'h0;
        repeat (10) @(posedge ref_clk);
        arst_n <= 1'h1;
    endtask : rst

    // ceiling well above the few hundred cycles the run needs
    always @(posedge ref_clk) begin
        cyc_cnt++;
        if (cyc_cnt == 5000) begin
            n_fail++;
            summarize();
        end
    end

    initial begin
        rst();
        foreach (rows[r]) begin
            for (int i = 0; i < 7; i++)
                wr(4'h7 + 4'(i), rows[r].al[55-8*i -: 8]);
            wr(4'hF, 8'h00);
            tk(rows[r].s[6:0]);
            chk("pin_no_ie", 8'h01, {7'h00, pin});
            rd(4'hF);
            chk("flags", {6'h00, rows[r].fl}, q);
            $display("test row %0d done", r);
        end
        wr(4'hE, 8'h1D);
        wr(4'hF, 8'h00);
        tk(7'h30);
        chk("pin_irq", 8'h00, {7'h00, pin});
        wr(4'hF, 8'h03);
        @(negedge ref_clk);
        chk("pin_keep", 8'h00, {7'h00, pin});
        rd(4'hF);
        chk("flag_keep", 8'h01, q);
        wr(4'hF, 8'h00);
        @(negedge ref_clk);
        chk("pin_clear", 8'h01, {7'h00, pin});
        wr(4'hE, 8'h1E);
        tk(7'h30);
        chk("pin_other_ie", 8'h01, {7'h00, pin});
        $display("test irq done");
        wr(4'hE, 8'h0B);
        @(negedge ref_clk);
        chk("rate", 8'h01, {6'h00, rate});
        for (int v = 0; v < 2; v++) begin
            @(posedge ref_clk);
            sq <= 1'(v);
            @(negedge ref_clk);
            chk("pin_wave", 8'(v), {7'h00, pin});
        end
        $display("test wave done");
        wr(4'hF, 8'h00);
        repeat (5) @(posedge ref_clk);
        rd(4'hF);
        chk("flags_no_tick", 8'h00, q);
        // tick and zero write taken at the same edge
        fork
            tk(7'h30);
            wr(4'hF, 8'h00);
        join
        rd(4'hF);
        chk("set_wins", 8'h01, q);
        wr(4'h3, 8'hFF);
        rd(4'h3);
        chk("unmapped", 8'h00, q);
        $display("test idle done");
        // mid-run reset with a flag standing
        tk(7'h30);
        @(posedge ref_clk);
        rst();
        rd(4'hE);
        chk("ctrl_reset", 8'h1C, q);
        rd(4'hF);
        chk("flag_reset", 8'h00, q);
        rd(4'h7);
        chk("alarm_reset", 8'h00, q);
        chk("rate_reset", 8'h03, {6'h00, rate});
        chk("pin_reset", 8'h01, {7'h00, pin});
        $display("test reset done");
        summarize();
    end
endmodule : tb
